// *** hdl/serial_delimiter_packer_pkg.sv ***
package serial_delimiter_packer_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLOCK_HZ       = 50_000_000;
  localparam int MS_PER_SECOND  = 1000;
  localparam int MS_PER_MINUTE  = 60_000;
  localparam int CYCLES_PER_MS  = CLOCK_HZ / MS_PER_SECOND;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFFSET_DELIMITER  = 8'h00;
  localparam logic [7:0] OFFSET_FORCE_TIME = 8'h04;
  localparam logic [7:0] OFFSET_IDLE_CLOSE = 8'h08;
  localparam logic [7:0] OFFSET_MAX_CONN   = 8'h0c;
  localparam logic [7:0] OFFSET_LINE_CFG   = 8'h10;
  localparam logic [7:0] OFFSET_STATUS     = 8'h14;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int DELIM_FIRST_LSB   = 0;
  localparam int DELIM_SECOND_LSB  = 8;
  localparam int STATUS_COUNT_LSB  = 0;
  localparam int STATUS_DRAIN_BIT  = 12;
  localparam int STATUS_HOSTS_LSB  = 16;
  localparam int STATUS_PAUSE_BIT  = 24;

  localparam logic [7:0]  DELIM_RESET      = 8'h00;
  localparam logic [15:0] FORCE_TIME_RESET = 16'h0000;
  localparam logic [6:0]  IDLE_CLOSE_RESET = 7'h07;
  localparam logic [6:0]  IDLE_CLOSE_MAX   = 7'h63;
  localparam logic [2:0]  MAX_CONN_RESET   = 3'h1;
  localparam logic [2:0]  MAX_CONN_LIMIT   = 3'h4;
  localparam logic [31:0] LINE_CFG_RESET   = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int BUFFER_BYTES = 1024;
  localparam int HOSTS        = 4;

  typedef enum {FILL, DRAIN} packer_state_type;

endpackage

// *** hdl/serial_delimiter_packer.sv ***
`timescale 1ns/1ps
module serial_delimiter_packer
  import serial_delimiter_packer_pkg::*;
#(
  parameter int MS_CYCLES    = CYCLES_PER_MS,
  parameter int MINUTE_MS    = MS_PER_MINUTE,
  parameter int BUFFER_DEPTH = BUFFER_BYTES
)(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        serial_rx_data,
  input  wire logic              serial_rx_valid,
  output logic                   serial_rx_ready,
  output logic [7:0]             frame_data,
  output logic                   frame_valid,
  output logic                   frame_last,
  input  wire logic              frame_ready,
  input  wire logic [7:0]        net_rx_data,
  input  wire logic              net_rx_valid,
  output logic                   net_rx_ready,
  output logic [7:0]             serial_tx_data,
  output logic                   serial_tx_valid,
  input  wire logic              serial_tx_ready,
  input  wire logic [HOSTS-1:0]  host_open_req,
  input  wire logic [HOSTS-1:0]  host_close_req,
  input  wire logic [HOSTS-1:0]  host_close_done,
  input  wire logic [HOSTS-1:0]  host_net_activity,
  input  wire logic [31:0]       host_line_cfg,
  input  wire logic              host_line_set,
  output logic [HOSTS-1:0]       host_granted,
  output logic [HOSTS-1:0]       host_idle_closed,
  output logic                   serial_paused,
  output logic [31:0]            serial_line_cfg
);

  localparam int CW = $clog2(BUFFER_DEPTH + 1);

  // ------------------------------------------------------------------
  // Registers and bus slave
  // ------------------------------------------------------------------
  logic [7:0]  delim_first;
  logic [7:0]  delim_second;
  logic [15:0] force_time;
  logic [6:0]  network_idle_close_time;
  logic [2:0]  max_conn;
  logic [31:0] line_cfg;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        aw_held;
  logic        w_held;
  logic [CW-1:0] fill_count;
  packer_state_type state;

  function automatic logic [31:0] merge(input logic [31:0] old_value,
                                        input logic [31:0] new_value,
                                        input logic [3:0]  strb);
    logic [31:0] result;
    result = old_value;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        result[8*b +: 8] = new_value[8*b +: 8];
    return result;
  endfunction

  // Address and data are latched independently, so either may come first.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  logic do_write;
  logic [31:0] merged;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr > OFFSET_LINE_CFG || wr_addr[1:0] != 2'h0)
                        ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Out-of-range limits are dropped so the stored settings stay legal.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      delim_first             <= DELIM_RESET;
      delim_second            <= DELIM_RESET;
      force_time              <= FORCE_TIME_RESET;
      network_idle_close_time <= IDLE_CLOSE_RESET;
      max_conn                <= MAX_CONN_RESET;
      line_cfg                <= LINE_CFG_RESET;
    end
    else if (do_write)
    begin
      case (wr_addr)
        OFFSET_DELIMITER:
        begin
          if (wr_strb[0])
            delim_first <= wr_data[DELIM_FIRST_LSB +: 8];
          if (wr_strb[1])
            delim_second <= wr_data[DELIM_SECOND_LSB +: 8];
        end
        OFFSET_FORCE_TIME:
          force_time <= merged[15:0];
        OFFSET_IDLE_CLOSE:
          if (wr_strb[0] && wr_data[7:0] <= {1'b0, IDLE_CLOSE_MAX})
            network_idle_close_time <= wr_data[6:0];
        OFFSET_MAX_CONN:
          if (wr_strb[0] && wr_data[7:0] != 8'h00
              && wr_data[7:0] <= {5'h00, MAX_CONN_LIMIT})
            max_conn <= wr_data[2:0];
        OFFSET_LINE_CFG:
          line_cfg <= merged;
        default:
          line_cfg <= line_cfg;
      endcase
    end
  end

  always_comb
  begin
    merged = merge(wr_addr == OFFSET_LINE_CFG ? line_cfg
                   : {16'h0000, force_time}, wr_data, wr_strb);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          OFFSET_DELIMITER:  s_axi_rdata <= {16'h0000, delim_second,
                                             delim_first};
          OFFSET_FORCE_TIME: s_axi_rdata <= {16'h0000, force_time};
          OFFSET_IDLE_CLOSE: s_axi_rdata <= {25'h0, network_idle_close_time};
          OFFSET_MAX_CONN:   s_axi_rdata <= {29'h0, max_conn};
          OFFSET_LINE_CFG:   s_axi_rdata <= line_cfg;
          OFFSET_STATUS:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rdata[STATUS_COUNT_LSB +: CW] <= fill_count;
            s_axi_rdata[STATUS_DRAIN_BIT] <= (state == DRAIN);
            s_axi_rdata[STATUS_HOSTS_LSB +: HOSTS] <= host_granted;
            s_axi_rdata[STATUS_PAUSE_BIT] <= serial_paused;
          end
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Millisecond and minute enables
  // ------------------------------------------------------------------
  logic [$clog2(MS_CYCLES)-1:0]   cycle_count;
  logic [$clog2(MINUTE_MS)-1:0]   ms_count;
  logic                           ms_tick;
  logic                           minute_tick;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      cycle_count <= '0;
      ms_count    <= '0;
      ms_tick     <= 1'b0;
      minute_tick <= 1'b0;
    end
    else
    begin
      ms_tick     <= (cycle_count == $bits(cycle_count)'(MS_CYCLES - 1));
      minute_tick <= 1'b0;
      cycle_count <= cycle_count + 1'b1;
      if (cycle_count == $bits(cycle_count)'(MS_CYCLES - 1))
        cycle_count <= '0;
      if (ms_tick)
      begin
        ms_count <= ms_count + 1'b1;
        if (ms_count == $bits(ms_count)'(MINUTE_MS - 1))
        begin
          ms_count    <= '0;
          minute_tick <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Serial-to-network packer
  // ------------------------------------------------------------------
  logic [7:0]    buffer [BUFFER_DEPTH];
  logic [CW-1:0] drain_ptr;
  logic [15:0]   idle_ms;
  logic          last_was_first;
  logic          rx_take;
  logic          byte_closes;
  logic          gap_closes;
  logic          delims_off;

  assign rx_take    = serial_rx_valid && serial_rx_ready;
  assign delims_off = (delim_first == 8'h00) && (delim_second == 8'h00);

  always_comb
  begin
    byte_closes = 1'b0;
    if (delims_off)
      byte_closes = 1'b1;
    else if (delim_second != 8'h00)
      byte_closes = last_was_first
                    && serial_rx_data == delim_second;
    else
      byte_closes = serial_rx_data == delim_first;
    if (fill_count == CW'(BUFFER_DEPTH - 1))
      byte_closes = 1'b1;
  end

  assign gap_closes = force_time != 16'h0000 && fill_count != '0
                      && idle_ms >= force_time;

  always_ff @(posedge ref_clk)
  begin
    if (rx_take)
      buffer[fill_count[CW-2:0]] <= serial_rx_data;
  end

  // A byte taken in the same cycle as a gap flush joins that frame.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state           <= FILL;
      fill_count      <= '0;
      drain_ptr       <= '0;
      idle_ms         <= 16'h0000;
      last_was_first  <= 1'b0;
      serial_rx_ready <= 1'b0;
      frame_valid     <= 1'b0;
      frame_last      <= 1'b0;
      frame_data      <= 8'h00;
    end
    else
    begin
      case (state)
        FILL:
        begin
          serial_rx_ready <= 1'b1;
          if (rx_take)
          begin
            fill_count     <= fill_count + 1'b1;
            idle_ms        <= 16'h0000;
            last_was_first <= serial_rx_data == delim_first;
          end
          else if (ms_tick && fill_count != '0 && idle_ms != 16'hffff)
            idle_ms <= idle_ms + 1'b1;
          if ((rx_take && byte_closes) || gap_closes)
          begin
            state           <= DRAIN;
            serial_rx_ready <= 1'b0;
            drain_ptr       <= '0;
          end
        end
        DRAIN:
        begin
          serial_rx_ready <= 1'b0;
          idle_ms         <= 16'h0000;
          last_was_first  <= 1'b0;
          if (!frame_valid || frame_ready)
          begin
            if (drain_ptr != fill_count && !serial_paused)
            begin
              frame_valid <= 1'b1;
              frame_data  <= buffer[drain_ptr[CW-2:0]];
              frame_last  <= drain_ptr == fill_count - 1'b1;
              drain_ptr   <= drain_ptr + 1'b1;
            end
            else
            begin
              frame_valid <= 1'b0;
              frame_last  <= 1'b0;
              if (drain_ptr == fill_count)
              begin
                state      <= FILL;
                fill_count <= '0;
              end
            end
          end
        end
        default:
          state <= FILL;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Network-to-serial path
  // ------------------------------------------------------------------
  // One holding stage keeps arrival order without any reordering buffer.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      serial_tx_valid <= 1'b0;
      serial_tx_data  <= 8'h00;
      net_rx_ready    <= 1'b0;
    end
    else
    begin
      if (net_rx_valid && net_rx_ready)
      begin
        serial_tx_valid <= 1'b1;
        serial_tx_data  <= net_rx_data;
      end
      else if (serial_tx_ready)
        serial_tx_valid <= 1'b0;
      net_rx_ready <= !serial_paused && !(net_rx_valid && net_rx_ready)
                      && (!serial_tx_valid || serial_tx_ready);
    end
  end

  // ------------------------------------------------------------------
  // Host connections
  // ------------------------------------------------------------------
  logic [HOSTS-1:0] closing;
  logic [6:0]       idle_minutes [HOSTS];
  logic [HOSTS-1:0] next_granted;
  logic [2:0]       open_count;

  always_comb
  begin
    next_granted = host_granted;
    open_count   = 3'h0;
    for (int h = 0; h < HOSTS; h++)
      open_count = open_count + {2'h0, host_granted[h]};
    for (int h = 0; h < HOSTS; h++)
      if (host_open_req[h] && !host_granted[h] && open_count < max_conn)
      begin
        next_granted[h] = 1'b1;
        open_count      = open_count + 3'h1;
      end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      host_granted     <= '0;
      host_idle_closed <= '0;
      closing          <= '0;
      serial_paused    <= 1'b0;
      for (int h = 0; h < HOSTS; h++)
        idle_minutes[h] <= 7'h00;
    end
    else
    begin
      host_granted     <= next_granted;
      host_idle_closed <= '0;
      for (int h = 0; h < HOSTS; h++)
      begin
        if (host_close_req[h] && host_granted[h])
          closing[h] <= 1'b1;
        if (host_close_done[h])
        begin
          closing[h]      <= 1'b0;
          host_granted[h] <= 1'b0;
        end
        if (!host_granted[h] || host_net_activity[h])
          idle_minutes[h] <= 7'h00;
        else if (minute_tick && network_idle_close_time != 7'h00)
          idle_minutes[h] <= idle_minutes[h] + 7'h01;
        if (host_granted[h] && network_idle_close_time != 7'h00
            && idle_minutes[h] >= network_idle_close_time)
        begin
          host_granted[h]     <= 1'b0;
          host_idle_closed[h] <= 1'b1;
          closing[h]          <= 1'b0;
          idle_minutes[h]     <= 7'h00;
        end
      end
      serial_paused <= max_conn > 3'h1 && |closing;
    end
  end

  // ------------------------------------------------------------------
  // Serial line parameters
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      serial_line_cfg <= LINE_CFG_RESET;
    else if (max_conn == 3'h1 && host_line_set)
      serial_line_cfg <= host_line_cfg;
    else if (max_conn != 3'h1 || do_write)
      serial_line_cfg <= line_cfg;
  end

endmodule // serial_delimiter_packer

// *** bench/packer_sva.sv ***
`timescale 1ns/1ps
module packer_sva
  import serial_delimiter_packer_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             reset,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             serial_rx_ready,
  input wire logic [7:0]       frame_data,
  input wire logic             frame_valid,
  input wire logic             frame_last,
  input wire logic             frame_ready,
  input wire logic             net_rx_ready,
  input wire logic [7:0]       serial_tx_data,
  input wire logic             serial_tx_valid,
  input wire logic             serial_tx_ready,
  input wire logic [HOSTS-1:0] host_open_req,
  input wire logic [HOSTS-1:0] host_granted,
  input wire logic [HOSTS-1:0] host_idle_closed,
  input wire logic             serial_paused
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence frame_end_s;
    frame_valid && frame_ready && frame_last;
  endsequence
  sequence held_pause_s;
    serial_paused ##1 serial_paused;
  endsequence

  a_rx_reopen:
    assert property (frame_end_s |-> ##[1:4] serial_rx_ready)
    else $error("serial input not reopened after frame");
  a_drain_closed:
    assert property (frame_valid |-> !serial_rx_ready)
    else $error("serial input open while draining");
  a_frame_hold:
    assert property (frame_valid && !frame_ready |=> frame_valid
      && $stable(frame_data) && $stable(frame_last))
    else $error("frame byte changed while stalled");
  a_tx_hold:
    assert property (serial_tx_valid && !serial_tx_ready |=>
      serial_tx_valid && $stable(serial_tx_data))
    else $error("serial output changed while stalled");
  a_pause_net:
    assert property (held_pause_s |-> !net_rx_ready)
    else $error("network bytes taken while paused");
  a_idle_owner:
    assert property (host_idle_closed != '0 |->
      (host_idle_closed & ~$past(host_granted)) == '0)
    else $error("idle close of an ungranted host");
  a_idle_pulse:
    assert property (host_idle_closed != '0 |=>
      (host_idle_closed & $past(host_idle_closed)) == '0)
    else $error("idle close pulse longer than one cycle");
  a_grant_cap:
    assert property ((host_granted & ~$past(host_granted|host_open_req)) == '0)
    else $error("grant without an open request");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
endmodule // packer_sva

bind serial_delimiter_packer packer_sva chk_u (.*);

// *** bench/far_side_model.sv ***
`timescale 1ns/1ps
module far_side_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  output logic      frame_ready,
  output logic      serial_tx_ready
);
  // Both sinks stall about one cycle in four to exercise held outputs.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      frame_ready     <= 1'b0;
      serial_tx_ready <= 1'b0;
    end
    else
    begin
      frame_ready     <= ($urandom_range(3) != 0);
      serial_tx_ready <= ($urandom_range(3) != 0);
    end
  end
endmodule // far_side_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import serial_delimiter_packer_pkg::*;
;
  localparam int MSC = 4, MIN = 3, DEPTH = 16;
  logic             ref_clk = 1'b0, reset = 1'b1;
  logic [7:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [7:0]       serial_rx_data = '0, net_rx_data = '0;
  logic [31:0]      s_axi_wdata = '0, host_line_cfg = '0;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic             s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic             s_axi_rready = 1'b0, serial_rx_valid = 1'b0;
  logic             net_rx_valid = 1'b0, host_line_set = 1'b0;
  logic [HOSTS-1:0] host_open_req = '0, host_close_req = '0;
  logic [HOSTS-1:0] host_close_done = '0, host_net_activity = '0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic             s_axi_arready, s_axi_rvalid, serial_rx_ready;
  logic             frame_valid, frame_last, frame_ready, net_rx_ready;
  logic             serial_tx_valid, serial_tx_ready, serial_paused;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [31:0]      s_axi_rdata, serial_line_cfg;
  logic [7:0]       frame_data, serial_tx_data;
  logic [HOSTS-1:0] host_granted, host_idle_closed;
  int               n_mismatch = 0, tests_run = 0;
  logic [8:0]       fq[$], tq[$];
  logic [33:0]      rq[$];
  logic [1:0]       bq[$];

  always #10ns ref_clk = ~ref_clk;

  serial_delimiter_packer #(.MS_CYCLES(MSC), .MINUTE_MS(MIN),
    .BUFFER_DEPTH(DEPTH)) dut_u (.*);
  far_side_model far_u (.*);

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp_word(input logic [33:0] got, exp, input string s);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [8:0] got, exp, input string s);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  task automatic ser(input logic [7:0] b, input logic last);
    fq.push_back({last, b});
    serial_rx_data <= b;
    serial_rx_valid <= 1'b1;
    do @(posedge ref_clk); while (!serial_rx_ready);
    serial_rx_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic net(input logic [7:0] b);
    tq.push_back({1'b0, b});
    net_rx_data <= b;
    net_rx_valid <= 1'b1;
    do @(posedge ref_clk); while (!net_rx_ready);
    net_rx_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && (fq.size() + tq.size()) > 0; i++)
      @(posedge ref_clk);
    cmp_word(34'(fq.size() + tq.size()), '0, "missing bytes");
  endtask
  function automatic logic [7:0] rb();
    return 8'($urandom_range(32, 255));
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      cmp_word({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x,
               "read");
    if (s_axi_bvalid && s_axi_bready)
      cmp_word(34'(s_axi_bresp), bq.size() ? 34'(bq.pop_front()) : 'x,
               "bresp");
    if (frame_valid && frame_ready)
      cmp_byte({frame_last, frame_data}, fq.size() ? fq.pop_front() : 'x,
               "frame");
    if (serial_tx_valid && serial_tx_ready)
      cmp_byte({1'b0, serial_tx_data}, tq.size() ? tq.pop_front() : 'x,
               "serial out");
  end

  initial
  begin
    #400us;
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [3:0] h;
    logic       seen;
    void'($urandom(32'hb4a66c79));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(OFFSET_DELIMITER, '0, RESP_OKAY);
    rd(OFFSET_FORCE_TIME, 32'(FORCE_TIME_RESET), RESP_OKAY);
    rd(OFFSET_LINE_CFG, LINE_CFG_RESET, RESP_OKAY);
    rd(8'h18, '0, RESP_SLVERR);
    wr(OFFSET_STATUS, 32'hffff_ffff, RESP_SLVERR);
    wr(OFFSET_IDLE_CLOSE, 32'h0000_0064, RESP_OKAY);
    wr(OFFSET_MAX_CONN, 32'h0000_0005, RESP_OKAY);
    rd(OFFSET_IDLE_CLOSE, 32'(IDLE_CLOSE_RESET), RESP_OKAY);
    rd(OFFSET_MAX_CONN, 32'(MAX_CONN_RESET), RESP_OKAY);
    for (int i = 0; i < 3; i++) ser(rb(), 1'b1);
    drain();
    // Second delimiter is only ever set together with the first.
    wr(OFFSET_DELIMITER, 32'h0000_000d, RESP_OKAY);
    ser(rb(), 1'b0);
    repeat (60) @(posedge ref_clk);
    cmp_word(34'(frame_valid), '0, "early frame");
    ser(8'h0d, 1'b1);
    wr(OFFSET_DELIMITER, 32'h0000_0a0d, RESP_OKAY);
    ser(8'h0a, 1'b0);
    ser(8'h0d, 1'b0);
    ser(rb(), 1'b0);
    ser(8'h0d, 1'b0);
    ser(8'h0a, 1'b1);
    for (int i = 0; i < DEPTH; i++) ser(rb(), i == DEPTH - 1);
    drain();
    // Three ms is well above one character time at any line rate used.
    wr(OFFSET_FORCE_TIME, 32'h0000_0003, RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      ser(rb(), i == 2);
      if (i < 2) repeat (4) @(posedge ref_clk);
    end
    drain();
    for (int i = 0; i < 6; i++) net(rb());
    drain();
    host_open_req <= 4'h3;
    @(posedge ref_clk);
    host_open_req <= '0;
    repeat (2) @(posedge ref_clk);
    cmp_word(34'($countones(host_granted)), 34'h1, "grants");
    host_close_req <= host_granted;
    @(posedge ref_clk);
    host_close_req <= '0;
    host_close_done <= host_granted;
    @(posedge ref_clk);
    host_close_done <= '0;
    wr(OFFSET_MAX_CONN, 32'h0000_0002, RESP_OKAY);
    host_open_req <= 4'h7;
    @(posedge ref_clk);
    host_open_req <= '0;
    host_line_cfg <= $urandom();
    host_line_set <= 1'b1;
    @(posedge ref_clk);
    host_line_set <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp_word(34'($countones(host_granted)), 34'h2, "grants");
    cmp_word(34'(serial_line_cfg), '0, "line cfg");
    h = host_granted & ~(host_granted - 4'h1);
    host_close_req <= h;
    @(posedge ref_clk);
    host_close_req <= '0;
    repeat (2) @(posedge ref_clk);
    cmp_word(34'(serial_paused), 34'h1, "pause");
    host_close_done <= h;
    @(posedge ref_clk);
    host_close_done <= '0;
    repeat (2) @(posedge ref_clk);
    cmp_word(34'(serial_paused), '0, "resume");
    host_net_activity <= host_granted;
    wr(OFFSET_IDLE_CLOSE, 32'h0000_0001, RESP_OKAY);
    host_net_activity <= '0;
    seen = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      if (host_idle_closed != '0) seen = 1'b1;
    end
    cmp_word(34'(seen), 34'h1, "idle close");
    cmp_word(34'(host_granted), '0, "idle grant");
    wr(OFFSET_IDLE_CLOSE, '0, RESP_OKAY);
    host_open_req <= 4'h8;
    @(posedge ref_clk);
    host_open_req <= '0;
    repeat (120) @(posedge ref_clk);
    cmp_word(34'(host_granted), 34'h8, "kept open");
    rd(OFFSET_STATUS, 32'h8 << STATUS_HOSTS_LSB, RESP_OKAY);
    cmp_word(34'(rq.size() + bq.size()), '0, "bus answers");
    wrap_up();
  end
endmodule // testbench
